// [pkg/tcc_pkg.sv]
// Shared constants for the cell tally and mode control block
package tcc_pkg;

  // Bus geometry: register index sits at haddr[11:2]
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RX_LOW   = 10'h038;
  localparam logic [9:0] IDX_RX_MID   = 10'h039;
  localparam logic [9:0] IDX_RX_HIGH  = 10'h03A;
  localparam logic [9:0] IDX_UNC      = 10'h03B;
  localparam logic [9:0] IDX_MIS_LOW  = 10'h03C;
  localparam logic [9:0] IDX_MIS_HIGH = 10'h03D;
  localparam logic [9:0] IDX_STATUS   = 10'h03E;
  localparam logic [9:0] IDX_MODE     = 10'h200;

  // Mode register fields
  localparam int MODE_MASTER_RST = 7;
  localparam int MODE_LOGIC_RST  = 6;
  localparam int MODE_STAT_LAT   = 5;
  localparam int MODE_CNTR_LAT   = 4;
  localparam int MODE_IRQ_EN     = 3;
  localparam int MODE_SEC_OUT    = 0;
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hF9;

  // Tally channels
  localparam int NUM_TALLY   = 3;
  localparam int TALLY_MAX_W = 19;
  localparam int CH_RX       = 0;
  localparam int CH_UNC      = 1;
  localparam int CH_MIS      = 2;
  localparam int TALLY_W [NUM_TALLY] = '{19, 8, 16};

  // Bus constants
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam logic        HRESP_OKAY = 1'h0;

  // One-second timing: 8 kHz reference derived from hclk
  localparam int CLK_PERIOD_NS  = 10;
  localparam int REF_PERIOD_NS  = 125000;
  localparam int REF_DIV_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REF_PER_SECOND = 8000;

endpackage

// [pkg/tcc_tally_if.sv]
// Carrier between the register front end and the tally bank
`timescale 1ns/1ps
interface tcc_tally_if;
  logic [tcc_pkg::NUM_TALLY-1:0]                          event_hit;
  logic [tcc_pkg::NUM_TALLY-1:0]                          clear;
  logic                                                   tick;
  logic                                                   latch;
  logic                                                   hold;
  logic [tcc_pkg::NUM_TALLY-1:0][tcc_pkg::TALLY_MAX_W-1:0] value;

  modport ctrl (output event_hit, output clear, output tick, output latch, output hold,
                input value);
  modport bank (input event_hit, input clear, input tick, input latch, input hold,
                output value);
endinterface

// [verilog/tcc_tally_bank.sv]
// Saturating event tallies with optional one-second latching
`timescale 1ns/1ps
module tcc_tally_bank (
  input wire logic   hclk,
  input wire logic   hresetn,
  tcc_tally_if.bank  tif
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [NUM_TALLY-1:0][TALLY_MAX_W-1:0] acc;
    logic [NUM_TALLY-1:0][TALLY_MAX_W-1:0] pres;
  } tcc_bank_state_t;

  tcc_bank_state_t st_q;
  tcc_bank_state_t st_d;

  // Per channel: count, latch at the second, clear on read
  always_comb begin
    logic [TALLY_MAX_W-1:0] max_v;
    logic [TALLY_MAX_W-1:0] inc_v;
    max_v = '0;
    inc_v = '0;
    st_d  = st_q;
    for (int i = 0; i < NUM_TALLY; i++) begin
      max_v = TALLY_MAX_W'((64'h1 << TALLY_W[i]) - 64'h1);
      // Hold at the top so overflow never reads as a small count
      inc_v = (st_q.acc[i] == max_v) ? st_q.acc[i] : TALLY_MAX_W'(st_q.acc[i] + 1'b1);
      if (tif.hold) begin
        st_d.acc[i]  = '0;
        st_d.pres[i] = '0;
      end else if (tif.latch) begin
        if (tif.tick) begin
          // Window closes: publish it, start a fresh one with this cycle's event
          st_d.pres[i] = st_q.acc[i];
          st_d.acc[i]  = tif.event_hit[i] ? TALLY_MAX_W'(1) : '0;
        end else begin
          if (tif.event_hit[i]) begin
            st_d.acc[i] = inc_v;
          end
          if (tif.clear[i]) begin
            st_d.pres[i] = '0;
          end
        end
      end else begin
        // Event in the clearing cycle survives as a count of one
        if (tif.clear[i]) begin
          st_d.acc[i] = tif.event_hit[i] ? TALLY_MAX_W'(1) : '0;
        end else if (tif.event_hit[i]) begin
          st_d.acc[i] = inc_v;
        end
      end
    end
  end

  // Visible value follows the latching mode
  for (genvar g = 0; g < NUM_TALLY; g++) begin : g_value
    assign tif.value[g] = tif.latch ? st_q.pres[g] : st_q.acc[g];
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// [verilog/tcc_cell_stats.sv]
// Cell tallies, event status and mode control behind an AHB-Lite slave
//
// Contract
// - Received cells counted in 19 bits over low, mid, high bytes; MSB at bit 2.
// - Reading any tally byte clears that count; here only low-byte reads do, mid and high reads clear a snapshot.
// - Uncorrectable header errors counted in one full 8-bit byte.
// - Mismatched cells counted in 16 bits over low and high bytes.
// - Upper five bits of the received-cell high byte read as zero.
// - Master reset bit holds machines in reset; all else returns to default.
// - Logic reset bit holds machines in reset; register contents unchanged.
// - Status latching shows only events between the last two seconds.
// - Latched status read clears it until the next second.
// - Without status latching, status accumulates all events since the last read.
// - Counter latching shows the count between the last two seconds.
// - Latched counter read clears it to zero until the next second.
// - Without counter latching, counter shows events since its last read.
// - Interrupt enable bit gates driving of the active-low interrupt pin.
// - Mode bits 2 and 1 are written zero and treated as zero.
// - Output mode: pin pulses once per 8000 periods of 8 kHz reference.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module tcc_cell_stats #(
  parameter int REF_DIV   = tcc_pkg::REF_DIV_CYCLES,
  parameter int REF_COUNT = tcc_pkg::REF_PER_SECOND
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [tcc_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       rx_cell_evt,
  input  wire logic                       unc_err_evt,
  input  wire logic                       mismatch_evt,
  input  wire logic                       irq_request,
  output logic                            processor_irq_n_o,
  output logic                            processor_irq_n_oe,
  input  wire logic                       second_pulse_pin_i,
  output logic                            second_pulse_pin_o,
  output logic                            second_pulse_pin_oe,
  output logic                            one_second_tick
);
  import tcc_pkg::*;

  localparam int DIV_W = $clog2(REF_DIV + 1);
  localparam int SEC_W = $clog2(REF_COUNT + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(REF_COUNT - 1);

  typedef struct packed {
    logic [7:0]           mode;
    logic                 wr_pend;
    logic [IDX_W-1:0]     wr_idx;
    logic [31:0]          rdata;
    logic [7:0]           rx_mid_snap;
    logic [2:0]           rx_high_snap;
    logic [7:0]           mis_high_snap;
    logic [2:0]           stat_live;
    logic [2:0]           stat_pres;
    logic [DIV_W-1:0]     div_cnt;
    logic [SEC_W-1:0]     sec_cnt;
    logic                 pulse_out;
    logic [2:0]           pin_sync;
    logic                 pin_level;
    logic                 tick;
    logic                 irq_n;
  } tcc_top_state_t;

  tcc_top_state_t st_q;
  tcc_top_state_t st_d;

  tcc_tally_if tif ();

  logic                 take;
  logic [IDX_W-1:0]     rd_idx;
  logic [7:0]           mode_now;
  logic                 master_rst;
  logic                 machines_held;
  logic [2:0]           evts;
  logic [2:0]           stat_view;
  logic                 ref_en;
  logic                 sec_internal;
  logic                 pin_fall;
  logic                 tick_now;
  logic [NUM_TALLY-1:0] clr;

  // Address phase qualifier; single word transfers only
  assign take   = hsel & htrans[1] & hready;
  assign rd_idx = haddr[ADDR_W-1:2];

  // Reset levels come from the stored mode so they act for whole cycles
  assign master_rst    = st_q.mode[MODE_MASTER_RST];
  assign machines_held = master_rst | st_q.mode[MODE_LOGIC_RST];

  // Events are dropped while the capture machines are held
  assign evts = machines_held ? 3'h0 : {mismatch_evt, unc_err_evt, rx_cell_evt};

  // 8 kHz enable and internal one-second event
  assign ref_en       = (st_q.div_cnt == DIV_LAST);
  assign sec_internal = ref_en & (st_q.sec_cnt == SEC_LAST);

  // Falling edge of the filtered pin level ends a low-high-low mark
  assign pin_fall = st_q.pin_level & ~st_q.pin_sync[2] & ~st_q.pin_sync[1];

  assign tick_now = ~machines_held &
                    (st_q.mode[MODE_SEC_OUT] ? sec_internal : pin_fall);

  // Status shown depends on the latching mode
  assign stat_view = st_q.mode[MODE_STAT_LAT] ? st_q.stat_pres : st_q.stat_live;

  // Mode after any write completing this cycle, used for read bypass too
  always_comb begin
    mode_now = st_q.mode;
    if (st_q.wr_pend && st_q.wr_idx == IDX_MODE) begin
      mode_now = hwdata[7:0] & MODE_WRITE_MASK;
    end
    if (mode_now[MODE_MASTER_RST]) begin
      mode_now = MODE_RESET | (8'h01 << MODE_MASTER_RST);
    end
  end

  // Main next-state logic
  always_comb begin
    st_d    = st_q;
    clr     = '0;
    st_d.mode    = mode_now;
    st_d.wr_pend = 1'b0;
    st_d.tick    = tick_now;
    st_d.irq_n   = ~irq_request;

    // Address phase: writes are finished in the data phase, reads answer now
    if (take) begin
      st_d.wr_pend = hwrite;
      st_d.wr_idx  = rd_idx;
      if (!hwrite) begin
        st_d.rdata = RDATA_ZERO;
        unique case (rd_idx)
          IDX_RX_LOW: begin
            st_d.rdata[7:0]   = tif.value[CH_RX][7:0];
            // Freeze upper bytes so the pair of later reads agrees
            st_d.rx_mid_snap  = tif.value[CH_RX][15:8];
            st_d.rx_high_snap = tif.value[CH_RX][18:16];
            clr[CH_RX]        = 1'b1;
          end
          IDX_RX_MID: begin
            st_d.rdata[7:0]  = st_q.rx_mid_snap;
            st_d.rx_mid_snap = 8'h00;
          end
          IDX_RX_HIGH: begin
            st_d.rdata[2:0]   = st_q.rx_high_snap;
            st_d.rx_high_snap = 3'h0;
          end
          IDX_UNC: begin
            st_d.rdata[7:0] = tif.value[CH_UNC][7:0];
            clr[CH_UNC]     = 1'b1;
          end
          IDX_MIS_LOW: begin
            st_d.rdata[7:0]    = tif.value[CH_MIS][7:0];
            st_d.mis_high_snap = tif.value[CH_MIS][15:8];
            clr[CH_MIS]        = 1'b1;
          end
          IDX_MIS_HIGH: begin
            st_d.rdata[7:0]    = st_q.mis_high_snap;
            st_d.mis_high_snap = 8'h00;
          end
          IDX_STATUS: begin
            st_d.rdata[2:0] = stat_view;
          end
          IDX_MODE: begin
            st_d.rdata[7:0] = mode_now;
          end
          default: begin
            st_d.rdata = RDATA_ZERO;
          end
        endcase
      end
    end

    // Status flags; a new event always beats a clearing read
    if (st_q.mode[MODE_STAT_LAT]) begin
      if (tick_now) begin
        st_d.stat_pres = st_q.stat_live;
        st_d.stat_live = evts;
      end else begin
        st_d.stat_live = st_q.stat_live | evts;
        if (take && !hwrite && rd_idx == IDX_STATUS) begin
          st_d.stat_pres = 3'h0;
        end
      end
    end else begin
      if (take && !hwrite && rd_idx == IDX_STATUS) begin
        st_d.stat_live = evts;
      end else begin
        st_d.stat_live = st_q.stat_live | evts;
      end
    end

    // Reference divider and second counter
    if (ref_en) begin
      st_d.div_cnt = '0;
      st_d.sec_cnt = sec_internal ? '0 : SEC_W'(st_q.sec_cnt + 1'b1);
    end else begin
      st_d.div_cnt = DIV_W'(st_q.div_cnt + 1'b1);
    end

    // Output pulse lasts one reference period
    if (sec_internal) begin
      st_d.pulse_out = 1'b1;
    end else if (ref_en) begin
      st_d.pulse_out = 1'b0;
    end

    // Pin synchroniser; level moves only once stages two and three agree
    st_d.pin_sync = {st_q.pin_sync[1:0], second_pulse_pin_i};
    if (st_q.pin_sync[1] == st_q.pin_sync[2]) begin
      st_d.pin_level = st_q.pin_sync[2];
    end

    // Logic reset: timing and edge machines held, stored values untouched
    if (machines_held) begin
      st_d.div_cnt   = '0;
      st_d.sec_cnt   = '0;
      st_d.pulse_out = 1'b0;
      st_d.pin_level = 1'b0;
      st_d.tick      = 1'b0;
    end

    // Master reset: every register except the reset bit to its default
    if (master_rst) begin
      st_d.rx_mid_snap   = 8'h00;
      st_d.rx_high_snap  = 3'h0;
      st_d.mis_high_snap = 8'h00;
      st_d.stat_live     = 3'h0;
      st_d.stat_pres     = 3'h0;
    end
  end

  // Tally bank hookup
  assign tif.event_hit = evts;
  assign tif.clear     = master_rst ? '0 : clr;
  assign tif.tick      = tick_now;
  assign tif.latch     = st_q.mode[MODE_CNTR_LAT];
  assign tif.hold      = master_rst;

  tcc_tally_bank u_bank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata    = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Interrupt pin is left floating unless enabled
  assign processor_irq_n_o  = st_q.irq_n;
  assign processor_irq_n_oe = st_q.mode[MODE_IRQ_EN];

  // One-second pin direction follows the mode
  assign second_pulse_pin_o  = st_q.pulse_out;
  assign second_pulse_pin_oe = st_q.mode[MODE_SEC_OUT];
  assign one_second_tick     = st_q.tick;

  // hsize is accepted but not checked: only whole words are expected
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule

// [verif/tcc_cell_stats_monitor.sv]
// Port assertions for the cell tally and mode control block
`timescale 1ns/1ps
module tcc_monitor #(
  parameter int REF_DIV   = 4,
  parameter int REF_COUNT = 5
) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [tcc_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       irq_request,
  input wire logic                       processor_irq_n_o,
  input wire logic                       processor_irq_n_oe,
  input wire logic                       second_pulse_pin_o,
  input wire logic                       second_pulse_pin_oe,
  input wire logic                       one_second_tick
);
  import tcc_pkg::*;
  logic        dp_q;
  logic        mst_q;
  logic [7:0]  wd_q;
  logic [15:0] hi_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Shadow of the last mode write, and length of the current pin pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q  <= 1'b0;
      mst_q <= 1'b0;
      wd_q  <= 8'h00;
      hi_q  <= 16'h0000;
    end else begin
      dp_q <= hsel && htrans[1] && hready && hwrite && haddr[11:2] == IDX_MODE;
      if (dp_q) begin
        wd_q  <= hwdata[7:0];
        mst_q <= hwdata[7];
      end
      hi_q <= second_pulse_pin_o ? hi_q + 16'h0001 : 16'h0000;
    end
  end

  // Read address phase taken at one register
  sequence s_rd(logic [9:0] idx);
    hsel && htrans[1] && hready && !hwrite && haddr[11:2] == idx;
  endsequence
  // Mode write: address phase, then data with master reset staying clear
  sequence s_mode_wr;
    hsel && htrans[1] && hready && hwrite && haddr[11:2] == IDX_MODE ##1 !hwdata[7] && !mst_q;
  endsequence

  a_rx_low_bytes: assert property (s_rd(IDX_RX_LOW) or s_rd(IDX_RX_MID) |=> hrdata[31:8] == '0)
    else $error("rx byte too wide");
  a_rx_high_zero: assert property (s_rd(IDX_RX_HIGH) |=> hrdata[31:3] == '0)
    else $error("rx high byte upper bits set");
  a_unc_one_byte: assert property (s_rd(IDX_UNC) |=> hrdata[31:8] == '0)
    else $error("unc byte too wide");
  a_mis_two_bytes: assert property (s_rd(IDX_MIS_LOW) or s_rd(IDX_MIS_HIGH) |=> hrdata[31:8] == '0)
    else $error("mismatch byte too wide");
  a_mode_reserved: assert property (s_rd(IDX_MODE) |=> hrdata[2:1] == 2'h0 && hrdata[31:8] == '0)
    else $error("mode reserved bits set");
  a_pin_direction: assert property (s_mode_wr |=> ##[0:1]
      (processor_irq_n_oe == wd_q[3] && second_pulse_pin_oe == wd_q[0]))
    else $error("pin enables do not follow mode");
  // A soft reset may legally cut a pulse short, so only uncut pulses are measured
  a_pulse_width: assert property ($fell(second_pulse_pin_o) && wd_q[7:6] == 2'h0 |->
      hi_q == REF_DIV)
    else $error("second pulse length wrong");
  // The first edge after release still shows the reset level of the pin register
  a_irq_follow: assert property ($past(hresetn) |-> processor_irq_n_o == !$past(irq_request))
    else $error("irq pin level wrong");
  a_tick_single: assert property (one_second_tick |=> !one_second_tick)
    else $error("tick longer than one cycle");
endmodule

bind tcc_cell_stats tcc_monitor #(.REF_DIV(REF_DIV), .REF_COUNT(REF_COUNT)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .irq_request(irq_request), .processor_irq_n_o(processor_irq_n_o),
  .processor_irq_n_oe(processor_irq_n_oe), .second_pulse_pin_o(second_pulse_pin_o),
  .second_pulse_pin_oe(second_pulse_pin_oe), .one_second_tick(one_second_tick));

// [verif/tb.sv]
// Self-checking bench for the cell tally and mode control block
`timescale 1ns/1ps
module tb;
  import tcc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, irq_request, ext_q;
  logic        irq_n_o, irq_n_oe, pin_o, pin_oe, tick, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  ev_q;
  logic [31:0] hwdata, hrdata, rd;
  wire logic   pin_lvl;
  int          bad_count, compares;

  // Pin level: the block in output mode, the bench otherwise
  assign pin_lvl = pin_oe ? pin_o : ext_q;

  // Short timer counts keep a second at twenty cycles
  tcc_cell_stats #(.REF_DIV(4), .REF_COUNT(5)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_cell_evt(ev_q[0]),
    .unc_err_evt(ev_q[1]), .mismatch_evt(ev_q[2]), .irq_request(irq_request),
    .processor_irq_n_o(irq_n_o), .processor_irq_n_oe(irq_n_oe),
    .second_pulse_pin_i(pin_lvl), .second_pulse_pin_o(pin_o),
    .second_pulse_pin_oe(pin_oe), .one_second_tick(tick));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready or tick, sampled mid-cycle, ending on a rising edge
  task automatic wt(input bit tk, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while ((tk ? tick : hreadyout) !== 1'b1 && n < lim);
    @(posedge hclk);
    if (n >= lim) begin
      chk(32'h0000_0000, 32'h0000_0001);
      stop_test();
    end
  endtask

  // One single AHB-Lite word transfer; read data kept in rd
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wt(1'b0, 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    wt(1'b0, 50);
    rd = hrdata;
  endtask

  task automatic rc(input logic [9:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, e});
    chk(32'(hresp), 32'h0000_0000);
  endtask

  // A spare edge after the strobe drops keeps back-to-back calls apart
  task automatic pulse(input int ch, input int n);
    ev_q[ch] <= 1'b1;
    repeat (n) @(posedge hclk);
    ev_q <= 3'b000;
    @(posedge hclk);
  endtask

  task automatic t_counts();
    rc(IDX_MODE, 8'h00);
    bus(1'b1, 10'h040, 8'hFF);
    rc(10'h040, 8'h00);
    pulse(0, 5);
    pulse(1, 3);
    pulse(2, 2);
    rc(IDX_STATUS, 8'h07);
    rc(IDX_RX_LOW, 8'h05);
    rc(IDX_RX_LOW, 8'h00);
    rc(IDX_UNC, 8'h03);
    rc(IDX_UNC, 8'h00);
    rc(IDX_MIS_LOW, 8'h02);
    $display("t_counts done");
  endtask

  // Carries into the upper bytes, capture at the low read, saturation
  task automatic t_wide();
    pulse(0, 300);
    rc(IDX_RX_LOW, 8'h2C);
    pulse(0, 1);
    rc(IDX_RX_MID, 8'h01);
    rc(IDX_RX_HIGH, 8'h00);
    rc(IDX_RX_LOW, 8'h01);
    pulse(2, 260);
    rc(IDX_MIS_LOW, 8'h04);
    rc(IDX_MIS_HIGH, 8'h01);
    pulse(1, 260);
    rc(IDX_UNC, 8'hFF);
    $display("t_wide done");
  endtask

  task automatic t_modes();
    // Status latching stays off here, so a stray second cannot move the flags
    bus(1'b1, IDX_MODE, 8'h1F);
    rc(IDX_MODE, 8'h19);
    bus(1'b1, IDX_MODE, 8'h00);
    rc(IDX_STATUS, 8'h07);
    pulse(0, 2);
    bus(1'b1, IDX_MODE, 8'h40);
    pulse(0, 4);
    rc(IDX_MODE, 8'h40);
    bus(1'b1, IDX_MODE, 8'h00);
    rc(IDX_RX_LOW, 8'h02);
    pulse(1, 3);
    bus(1'b1, IDX_MODE, 8'h89);
    pulse(1, 2);
    rc(IDX_MODE, 8'h80);
    rc(IDX_UNC, 8'h00);
    bus(1'b1, IDX_MODE, 8'h00);
    rc(IDX_MODE, 8'h00);
    $display("t_modes done");
  endtask

  // Events inside one second stay hidden until the following tick
  task automatic t_latch();
    bus(1'b1, IDX_MODE, 8'h31);
    wt(1'b1, 60);
    bus(1'b0, IDX_UNC, 8'h00);
    bus(1'b0, IDX_STATUS, 8'h00);
    pulse(1, 3);
    rc(IDX_UNC, 8'h00);
    rc(IDX_STATUS, 8'h00);
    wt(1'b1, 60);
    rc(IDX_UNC, 8'h03);
    rc(IDX_UNC, 8'h00);
    rc(IDX_STATUS, 8'h02);
    chk(32'(pin_oe), 32'h0000_0001);
    bus(1'b1, IDX_MODE, 8'h00);
    $display("t_latch done");
  endtask

  task automatic t_input();
    bus(1'b1, IDX_MODE, 8'h08);
    irq_request <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(32'(irq_n_o), 32'h0000_0000);
    chk(32'(irq_n_oe), 32'h0000_0001);
    ext_q <= 1'b1;
    repeat (4) @(posedge hclk);
    ext_q <= 1'b0;
    wt(1'b1, 10);
    bus(1'b1, IDX_MODE, 8'h00);
    repeat (2) @(posedge hclk);
    chk(32'(irq_n_oe), 32'h0000_0000);
    $display("t_input done");
  endtask

  // Reset for two cycles, then every scenario in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    ev_q = 3'b000;
    irq_request = 1'b0;
    ext_q = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_counts();
    t_wide();
    t_modes();
    t_latch();
    t_input();
    stop_test();
  end
endmodule
